// ### plps_pkg.sv
/*
 * Package for the power-loss path sequencer: timing constants, states and port structs.
 * Assumes a 125 MHz core clock.
 */
package plps_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned START_TMO_MS  = 1000;
    localparam int unsigned RETRY_OFF_MS  = 1000;
    localparam int unsigned HICCUP_PER_MS = 2000;
    localparam int unsigned OVLD_TMO_MS   = 1000;
    localparam int unsigned START_TMO_CYC = START_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned RETRY_OFF_CYC = RETRY_OFF_MS * (CLK_HZ / 1000);
    localparam int unsigned HICCUP_CYC    = HICCUP_PER_MS * (CLK_HZ / 1000);
    localparam int unsigned OVLD_TMO_CYC  = OVLD_TMO_MS * (CLK_HZ / 1000);
    localparam int unsigned SYNC_STAGES   = 3;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic RST_PWR_LOSS_FLAG = 1'b0;
    localparam logic RST_DISCHARGE     = 1'b1;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        PLPS_ST_DISABLED,
        PLPS_ST_SOFTSTART,
        PLPS_ST_NORMAL,
        PLPS_ST_SUPPLEMENT,
        PLPS_ST_SHUTDOWN,
        PLPS_ST_UVRESET
    } plps_main_t;

    typedef enum logic [1:0] {
        PLPS_SP_OFF,
        PLPS_SP_SOFT,
        PLPS_SP_FULL,
        PLPS_SP_RETRY
    } plps_path_t;

    // Analog comparator outputs, all asynchronous to the core clock.
    typedef struct packed {
        logic main_enable;
        logic input_valid;
        logic sense_under;
        logic sense_over;
        logic vin_over;
        logic sw_over_curr;
        logic vin_vout_300;
        logic ilim_clamp_more;
        logic ss_over_90;
        logic input_ss_done;
        logic path_across_zero;
        logic path_below_560;
        logic path_overload;
        logic store_charged;
        logic store_in_reg;
        logic store_below_95;
        logic fb_below_95;
        logic storage_depleted;
        logic buck_enabled;
        logic uv_reset_event;
    } plps_sense_t;

    localparam int unsigned SENSE_W = $bits(plps_sense_t);

    typedef struct packed {
        logic input_switch_on;
        logic path_switch_on;
        logic path_soft_limit;
        logic boost_enable;
    } plps_drive_t;

endpackage

// ### plps_sequencer.sv
/*
 * Power-loss path sequencer: input switch, storage-path switch, indicators, discharge.
 * Assumes comparator levels arrive asynchronously and the host reads faults by a pulse.
 */
// Notes on behaviour
// (R01) power_loss_flag rises after input soft-start and stays high in normal operation.
// (R02) power_loss_flag drops immediately on entering supplement mode.
// (R03) Entering undervolt reset state turns the discharge switch on.
// (R04) discharge_force_bit high turns the discharge switch on in any state.
// (R05) storage_good_flag rises at regulation, falls below 95 percent of setpoint.
// (R06) storage_good_flag forced low while buck or boost is disabled.
// (R07) output_good_flag rises only after the input switch is fully on.
// (R08) In supplement, output_good_flag starts high, drops when feedback below 95 percent.
// (R09) Input switch opens on sense under/over, input over, overcurrent, or 300mV drop.
// (R10) Path switch soft-starts at 300mA until voltage nears zero, then full with 1.8A.
// (R11) Path switch returns to soft-start when output minus node rises above 560mV.
// (R12) Storage not charged within 1s: switch off 1s, then retry.
// (R13) Overload beyond 1s: hiccup the path switch with a 2s period.
// (R14) Current limit pulling node low flags a node undervoltage fault and alert.
// (R15) Node 560mV below output lowers limit to 300mA; input switch stays on.
// (R16) Select 0 takes path control from the pin; select 1 from the register bit.
// (R17) Selected control low turns the path switch off, high turns it on.
// (R18) Path switch disabled also holds the boost converter disabled.
// (R19) Input switch clamps at current limit and opens if load draws more.
// (R20) Soft-start current above 90 percent of limit: shutdown, open, retry soft-start.
// (R21) Output tied to input in normal operation, disconnected throughout supplement.
// (R22) Main enable low with valid input enters supplement, disables after depletion.
// (R23) Alert stays low until the fault is read, and stays low while fault persists.
// (R24) The 1s and 2s intervals come from counters derived from the clock rate.
// (R25) Comparator outputs are synchronised through flip-flops before any decision.
`timescale 1ns/1ns
module plps_sequencer
    import plps_pkg::*;
#(
    parameter int unsigned START_CYC  = START_TMO_CYC,
    parameter int unsigned RETRY_CYC  = RETRY_OFF_CYC,
    parameter int unsigned HICCUP_PER = HICCUP_CYC,
    parameter int unsigned OVLD_CYC   = OVLD_TMO_CYC
) (
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire plps_sense_t sense_i,
    input  wire logic        store_path_enable_pin_i,
    input  wire logic        block_switch_bit_i,
    input  wire logic        block_ctrl_select_i,
    input  wire logic        discharge_force_bit_i,
    input  wire logic        fault_read_i,
    output plps_drive_t      drive_o,
    output logic             power_loss_flag_o,
    output logic             storage_good_flag_o,
    output logic             output_good_flag_o,
    output logic             discharge_switch_o,
    output logic             fault_alert_n_o,
    output logic             node_uv_fault_o
);

    initial begin
        if (START_CYC < 2 || RETRY_CYC < 2 || HICCUP_PER < 4 || OVLD_CYC < 2) begin
            $error("plps_sequencer: timing counts too small");
        end
    end

    localparam int unsigned CW = 32;

    // ==========================================================
    // Synchronisers
    // ==========================================================
    logic [SENSE_W-1:0] sync_q [SYNC_STAGES];
    logic [SENSE_W-1:0] filt_q;
    plps_sense_t        s;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_q[0] <= '0;
            sync_q[1] <= '0;
            sync_q[2] <= '0;
        end else begin
            sync_q[0] <= sense_i;
            sync_q[1] <= sync_q[0];
            sync_q[2] <= sync_q[1];
        end
    end

    // A change is accepted only once the second and third stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < SENSE_W; gi++) begin : g_filt
            always_ff @(posedge core_clk_i or posedge reset_i) begin
                if (reset_i) begin
                    filt_q[gi] <= 1'b0;
                end else if (sync_q[1][gi] == sync_q[2][gi]) begin
                    filt_q[gi] <= sync_q[2][gi]; // R25
                end
            end
        end
    endgenerate

    assign s = plps_sense_t'(filt_q);

    logic sel_q [3];
    logic sel_f_q;
    logic path_req;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sel_q[0] <= 1'b0;
            sel_q[1] <= 1'b0;
            sel_q[2] <= 1'b0;
            sel_f_q  <= 1'b0;
        end else begin
            sel_q[0] <= store_path_enable_pin_i;
            sel_q[1] <= sel_q[0];
            sel_q[2] <= sel_q[1];
            if (sel_q[1] == sel_q[2]) begin
                sel_f_q <= sel_q[2];
            end
        end
    end

    assign path_req = block_ctrl_select_i ? block_switch_bit_i : sel_f_q; // R16 R17

    // ==========================================================
    // Main state machine
    // ==========================================================
    plps_main_t main_q;
    plps_main_t main_d;
    logic       in_trip;

    // R09 R19
    assign in_trip = s.sense_under | s.sense_over | s.vin_over | s.sw_over_curr
                   | s.vin_vout_300 | s.ilim_clamp_more;

    always_comb begin
        main_d = main_q;
        case (main_q)
            PLPS_ST_DISABLED: begin
                if (s.main_enable && s.input_valid && !s.sense_under) begin
                    main_d = PLPS_ST_SOFTSTART;
                end
            end
            PLPS_ST_SOFTSTART: begin
                if (s.ss_over_90) begin
                    main_d = PLPS_ST_SHUTDOWN; // R20
                end else if (!s.main_enable || in_trip) begin
                    main_d = PLPS_ST_DISABLED;
                end else if (s.input_ss_done) begin
                    main_d = PLPS_ST_NORMAL;
                end
            end
            PLPS_ST_NORMAL: begin
                if (in_trip || !s.main_enable) begin
                    main_d = PLPS_ST_SUPPLEMENT; // R22
                end
            end
            PLPS_ST_SUPPLEMENT: begin
                if (s.storage_depleted || s.uv_reset_event) begin
                    main_d = PLPS_ST_UVRESET; // R22
                end
            end
            PLPS_ST_SHUTDOWN: begin
                main_d = PLPS_ST_SOFTSTART; // R20
            end
            PLPS_ST_UVRESET: begin
                if (!s.uv_reset_event && !s.storage_depleted) begin
                    main_d = PLPS_ST_DISABLED;
                end
            end
            default: main_d = PLPS_ST_DISABLED;
        endcase
        if (s.uv_reset_event) begin
            main_d = PLPS_ST_UVRESET;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            main_q <= PLPS_ST_UVRESET;
        end else begin
            main_q <= main_d;
        end
    end

    // ==========================================================
    // Storage-path switch
    // ==========================================================
    plps_path_t path_q;
    logic [CW-1:0] tmr_q;
    logic [CW-1:0] ovl_q;
    logic          hiccup_q;
    logic          path_allow;

    assign path_allow = path_req && (main_q != PLPS_ST_DISABLED)
                      && (main_q != PLPS_ST_UVRESET);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            path_q   <= PLPS_SP_OFF;
            tmr_q    <= '0;
            hiccup_q <= 1'b0;
        end else if (!path_allow) begin
            path_q   <= PLPS_SP_OFF; // R17
            tmr_q    <= '0;
            hiccup_q <= 1'b0;
        end else begin
            case (path_q)
                PLPS_SP_OFF: begin
                    path_q <= PLPS_SP_SOFT;
                    tmr_q  <= '0;
                end
                PLPS_SP_SOFT: begin
                    if (s.path_across_zero && s.store_charged && !s.path_below_560) begin
                        path_q <= PLPS_SP_FULL; // R10 R12
                    end else if (tmr_q >= START_CYC - 1) begin
                        path_q   <= PLPS_SP_RETRY; // R12 R24
                        tmr_q    <= '0;
                        hiccup_q <= 1'b0;
                    end else begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                PLPS_SP_FULL: begin
                    tmr_q <= '0;
                    if (ovl_q >= OVLD_CYC - 1) begin
                        path_q   <= PLPS_SP_RETRY; // R13
                        hiccup_q <= 1'b1;
                    end else if (s.path_below_560) begin
                        path_q <= PLPS_SP_SOFT; // R11
                    end
                end
                PLPS_SP_RETRY: begin
                    if (tmr_q >= (hiccup_q ? HICCUP_PER / 2 : RETRY_CYC) - 1) begin
                        path_q <= PLPS_SP_SOFT; // R12 R13 R24
                        tmr_q  <= '0;
                    end else begin
                        tmr_q <= tmr_q + 1'b1;
                    end
                end
                default: path_q <= PLPS_SP_OFF;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ovl_q <= '0;
        end else if (path_q == PLPS_SP_FULL && s.path_overload) begin
            ovl_q <= ovl_q + 1'b1; // R13
        end else begin
            ovl_q <= '0;
        end
    end

    // ==========================================================
    // Drive outputs
    // ==========================================================
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            drive_o <= '0;
        end else begin
            drive_o.input_switch_on <= (main_d == PLPS_ST_NORMAL) && !in_trip; // R21 R09 R15
            drive_o.path_switch_on  <= (path_q == PLPS_SP_SOFT) || (path_q == PLPS_SP_FULL);
            drive_o.path_soft_limit <= (path_q != PLPS_SP_FULL) || s.path_below_560; // R10 R15
            drive_o.boost_enable    <= (path_q == PLPS_SP_FULL) && (main_q == PLPS_ST_NORMAL); // R18
        end
    end

    // ==========================================================
    // Indicators
    // ==========================================================
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            power_loss_flag_o <= RST_PWR_LOSS_FLAG;
        end else begin
            power_loss_flag_o <= (main_d == PLPS_ST_NORMAL); // R01 R02
        end
    end

    logic boost_on;
    assign boost_on = (path_q == PLPS_SP_FULL) && (main_q == PLPS_ST_NORMAL);

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            storage_good_flag_o <= 1'b0;
        end else if (!s.buck_enabled || !boost_on || !path_allow) begin
            storage_good_flag_o <= 1'b0; // R06
        end else if (s.store_below_95) begin
            storage_good_flag_o <= 1'b0; // R05
        end else if (s.store_in_reg) begin
            storage_good_flag_o <= 1'b1; // R05
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            output_good_flag_o <= 1'b0;
        end else if (main_q == PLPS_ST_SUPPLEMENT) begin
            if (s.fb_below_95) begin
                output_good_flag_o <= 1'b0; // R08
            end
        end else begin
            output_good_flag_o <= drive_o.input_switch_on; // R07
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            discharge_switch_o <= RST_DISCHARGE;
        end else begin
            discharge_switch_o <= (main_d == PLPS_ST_UVRESET) || discharge_force_bit_i; // R03 R04
        end
    end

    // ==========================================================
    // Fault alert
    // ==========================================================
    logic node_uv;
    assign node_uv = s.path_overload && s.path_below_560 && drive_o.path_switch_on;

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            node_uv_fault_o <= 1'b0;
            fault_alert_n_o <= 1'b1;
        end else if (node_uv) begin
            node_uv_fault_o <= 1'b1; // R14
            fault_alert_n_o <= 1'b0; // R14 R23
        end else if (fault_read_i) begin
            node_uv_fault_o <= 1'b0; // R23
            fault_alert_n_o <= 1'b1;
        end
    end

endmodule

// ### plps_sequencer_checker.sv
/* Checker for the power-loss path sequencer ports.
   Assumes it is bound to plps_sequencer and sees only its ports. */
`timescale 1ns/1ns
module plps_sequencer_checker
    import plps_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        reset_i,
    input wire plps_sense_t sense_i,
    input wire logic        store_path_enable_pin_i,
    input wire logic        block_switch_bit_i,
    input wire logic        block_ctrl_select_i,
    input wire logic        discharge_force_bit_i,
    input wire logic        fault_read_i,
    input wire plps_drive_t drive_o,
    input wire logic        power_loss_flag_o,
    input wire logic        storage_good_flag_o,
    input wire logic        output_good_flag_o,
    input wire logic        discharge_switch_o,
    input wire logic        fault_alert_n_o,
    input wire logic        node_uv_fault_o
);
    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    a_flag_on_input: assert property ($rose(power_loss_flag_o) |-> ##[0:1] drive_o.input_switch_on)
        else $error("Power loss flag rose without the input switch on.");
    a_flag_drop_open: assert property ($fell(drive_o.input_switch_on) |-> ##[0:2] !power_loss_flag_o)
        else $error("Input switch opened but power loss flag stayed high.");
    a_force_discharge: assert property (discharge_force_bit_i [*6] |-> discharge_switch_o)
        else $error("Forced discharge did not turn the discharge switch on.");
    a_store_good_low: assert property ((!sense_i.buck_enabled || !drive_o.boost_enable) [*6]
        |-> !storage_good_flag_o)
        else $error("Storage good high while a converter is disabled.");
    a_out_good_rise: assert property ($rose(output_good_flag_o)
        |-> drive_o.input_switch_on || $past(drive_o.input_switch_on))
        else $error("Output good rose before the input switch was on.");
    a_input_trip_open: assert property ((sense_i.sense_over || sense_i.vin_over) [*8]
        |-> !drive_o.input_switch_on)
        else $error("Input switch stayed on through an overvoltage.");
    a_path_soft_first: assert property ($rose(drive_o.path_switch_on) |-> drive_o.path_soft_limit)
        else $error("Path switch turned on without soft-start limit.");
    a_uv_fault_alert: assert property ($rose(node_uv_fault_o) |-> ##[0:2] !fault_alert_n_o)
        else $error("Node undervoltage fault without alert.");
    a_bit_off_path: assert property ((block_ctrl_select_i && !block_switch_bit_i) [*6]
        |-> !drive_o.path_switch_on)
        else $error("Path switch on while the selected bit is low.");
    a_pin_off_path: assert property ((!block_ctrl_select_i && !store_path_enable_pin_i) [*8]
        |-> !drive_o.path_switch_on)
        else $error("Path switch on while the selected pin is low.");
    a_boost_needs_path: assert property (!drive_o.path_switch_on [*2] |-> !drive_o.boost_enable)
        else $error("Boost enabled with the path switch off.");
    a_alert_held_low: assert property (!fault_alert_n_o && !fault_read_i |=> !fault_alert_n_o)
        else $error("Alert released without a fault read.");
endmodule

// ### plps_host_model.sv
/* Host model: drives the path-enable pin and pulses the fault read.
   Assumes the bench sets the requested levels between clock edges. */
`timescale 1ns/1ns
module plps_host_model (
    input  wire logic core_clk_i,
    input  wire logic path_cmd_i,
    input  wire logic read_req_i,
    output logic      path_pin_o,
    output logic      fault_read_o
);
    // ==========================================================
    // Pin and read pulse
    // ==========================================================
    logic seen_q;
    initial begin
        path_pin_o   = 1'h0;
        fault_read_o = 1'h0;
        seen_q       = 1'h0;
    end
    always @(negedge core_clk_i) begin
        path_pin_o   <= path_cmd_i;
        fault_read_o <= read_req_i != seen_q;
        seen_q       <= read_req_i;
    end
endmodule

// ### plps_sequencer_tb.sv
/* Self-checking bench for the power-loss path sequencer.
   Assumes short timing parameters and the host model on the pin side. */
`timescale 1ns/1ns
module plps_sequencer_tb
    import plps_pkg::*;
;
    // ==========================================================
    // Signals
    // ==========================================================
    localparam int ST = 16;
    localparam int RT = 16;
    localparam int HP = 48;
    localparam int OV = 16;
    localparam int PLF = 9, SGF = 8, OGF = 7, DIS = 6, ALN = 5, UVF = 4;
    localparam int ISW = 3, PSW = 2, SFT = 1, BST = 0;
    localparam logic [9:0] RSTV = 10'h060;
    logic        clk = 1'h0;
    logic        rst = 1'h1;
    plps_sense_t sense = '0;
    logic        sel = 1'h0;
    logic        bsw = 1'h0;
    logic        frc = 1'h0;
    logic        cmd = 1'h0;
    logic        req = 1'h0;
    logic        pin, rd, plf, sgf, ogf, dis, aln, uvf;
    plps_drive_t drv;
    wire logic [9:0] outs = {plf, sgf, ogf, dis, aln, uvf, drv};
    int          mismatches = 0;
    int          cmp_count = 0;

    always #4 clk = ~clk;

    plps_sequencer #(.START_CYC(ST), .RETRY_CYC(RT), .HICCUP_PER(HP), .OVLD_CYC(OV)) uut (
        .core_clk_i(clk), .reset_i(rst), .sense_i(sense),
        .store_path_enable_pin_i(pin), .block_switch_bit_i(bsw),
        .block_ctrl_select_i(sel), .discharge_force_bit_i(frc), .fault_read_i(rd),
        .drive_o(drv), .power_loss_flag_o(plf), .storage_good_flag_o(sgf),
        .output_good_flag_o(ogf), .discharge_switch_o(dis),
        .fault_alert_n_o(aln), .node_uv_fault_o(uvf));

    plps_host_model host (.core_clk_i(clk), .path_cmd_i(cmd), .read_req_i(req),
        .path_pin_o(pin), .fault_read_o(rd));

    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic chk(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wt(input int i, input logic v, input int lim);
        int n = 0;
        while (outs[i] !== v && n < lim) begin
            tick(1);
            n++;
        end
        chk(outs[i], v, "awaited output level");
    endtask

    task automatic gap(input logic v, input int lo, input int hi);
        int n = 0;
        while (outs[PSW] === v && n <= hi) begin
            tick(1);
            n++;
        end
        chk(n >= lo && n <= hi, 1'h1, "path switch interval");
    endtask

    task automatic read_fault();
        req = ~req;
        tick(3);
    endtask

    task automatic boot();
        sense = '0;
        sense.buck_enabled = 1'h1;
        {sel, bsw, frc, cmd} = 4'h0;
        rst = 1'h1;
        tick(16);
        for (int i = 0; i < 10; i++) chk(outs[i], RSTV[i], "reset value");
        rst = 1'h0;
        sense.main_enable = 1'h1;
        sense.input_valid = 1'h1;
        tick(2);
        sense.input_ss_done = 1'h1;
        wt(PLF, 1'h1, 40);
        chk(outs[ISW], 1'h1, "input switch on");
        wt(OGF, 1'h1, 12);
    endtask

    task automatic trip(input int k);
        boot();
        case (k)
            0: sense.sense_under = 1'h1;
            1: sense.sense_over = 1'h1;
            2: sense.vin_over = 1'h1;
            3: sense.sw_over_curr = 1'h1;
            4: sense.vin_vout_300 = 1'h1;
            5: sense.ilim_clamp_more = 1'h1;
            default: sense.main_enable = 1'h0;
        endcase
        wt(PLF, 1'h0, 12);
        chk(outs[ISW], 1'h0, "input switch open");
        chk(outs[OGF], 1'h1, "output good in supplement");
        sense.fb_below_95 = 1'h1;
        wt(OGF, 1'h0, 12);
        sense.storage_depleted = 1'h1;
        wt(DIS, 1'h1, 12);
    endtask

    task automatic give_verdict();
        $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Tests
    // ==========================================================
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    initial begin
        for (int k = 0; k < 7; k++) trip(k);
        boot();
        cmd = 1'h1;
        wt(PSW, 1'h1, 20);
        gap(1'h1, ST - 2, ST + 4);
        gap(1'h0, RT - 1, RT + 1);
        sense.store_charged = 1'h1;
        sense.path_across_zero = 1'h1;
        sense.path_overload = 1'h1;
        gap(1'h1, 1, OV + 12);
        gap(1'h0, HP / 2 - 1, HP / 2 + 1);
        boot();
        cmd = 1'h1;
        wt(PSW, 1'h1, 20);
        chk(outs[SFT], 1'h1, "soft limit at start");
        sense.store_charged = 1'h1;
        sense.path_across_zero = 1'h1;
        wt(SFT, 1'h0, 12);
        wt(BST, 1'h1, 12);
        sense.store_in_reg = 1'h1;
        wt(SGF, 1'h1, 12);
        sense.store_below_95 = 1'h1;
        wt(SGF, 1'h0, 12);
        sense.store_below_95 = 1'h0;
        wt(SGF, 1'h1, 12);
        sense.buck_enabled = 1'h0;
        wt(SGF, 1'h0, 12);
        frc = 1'h1;
        wt(DIS, 1'h1, 8);
        frc = 1'h0;
        wt(DIS, 1'h0, 8);
        sense.path_below_560 = 1'h1;
        wt(SFT, 1'h1, 12);
        chk(outs[ISW], 1'h1, "input switch kept on");
        sense.path_overload = 1'h1;
        wt(UVF, 1'h1, 12);
        wt(ALN, 1'h0, 4);
        read_fault();
        chk(outs[ALN], 1'h0, "alert kept while fault persists");
        sense.path_overload = 1'h0;
        sense.path_below_560 = 1'h0;
        tick(6);
        read_fault();
        wt(ALN, 1'h1, 8);
        sel = 1'h1;
        wt(PSW, 1'h0, 10);
        bsw = 1'h1;
        wt(PSW, 1'h1, 10);
        cmd = 1'h0;
        tick(8);
        chk(outs[PSW], 1'h1, "pin ignored when bit selected");
        sel = 1'h0;
        wt(PSW, 1'h0, 12);
        rst = 1'h1;
        sense = '0;
        tick(16);
        rst = 1'h0;
        sense.main_enable = 1'h1;
        sense.input_valid = 1'h1;
        sense.input_ss_done = 1'h1;
        sense.ss_over_90 = 1'h1;
        tick(12);
        chk(outs[PLF], 1'h0, "no start above soft-start limit");
        chk(outs[ISW], 1'h0, "input switch open in shutdown");
        sense.ss_over_90 = 1'h0;
        wt(PLF, 1'h1, 12);
        give_verdict();
    end
endmodule

bind plps_sequencer plps_sequencer_checker chk_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .sense_i(sense_i),
    .store_path_enable_pin_i(store_path_enable_pin_i),
    .block_switch_bit_i(block_switch_bit_i), .block_ctrl_select_i(block_ctrl_select_i),
    .discharge_force_bit_i(discharge_force_bit_i), .fault_read_i(fault_read_i),
    .drive_o(drive_o), .power_loss_flag_o(power_loss_flag_o),
    .storage_good_flag_o(storage_good_flag_o), .output_good_flag_o(output_good_flag_o),
    .discharge_switch_o(discharge_switch_o), .fault_alert_n_o(fault_alert_n_o),
    .node_uv_fault_o(node_uv_fault_o));
